// ---- verilog/vclamp_regs.svh ----
/*
  Register map, field positions and reset values of the vertical sync,
  coast and clamp control block.
  Assumes inclusion by bare name wherever the block is compiled.
*/
`ifndef VCLAMP_REGS_SVH
`define VCLAMP_REGS_SVH

`define VS_CTRL_ADDR  8'h14
`define VS_WIDTH_ADDR 8'h15
`define LEAD_ADDR     8'h16
`define TRAIL_ADDR    8'h17
`define CC_SEL_ADDR   8'h18
`define CL_START_ADDR 8'h19
`define CL_WIDTH_ADDR 8'h1a
`define CL_POL_ADDR   8'h1b
`define STATUS_ADDR   8'h1c
`define REG_NUM       8

`define VS_CTRL_RST   8'h18
`define VS_WIDTH_RST  8'h0a
`define LEAD_RST      8'h00
`define TRAIL_RST     8'h00
`define CC_SEL_RST    8'h20
`define CL_START_RST  8'h08
`define CL_WIDTH_RST  8'h14
`define CL_POL_RST    8'h58
`define LOW_BIT_MASK  8'hfe
`define FULL_MASK     8'hff

`define VS_SRC_OVR    7
`define VS_SRC_SEL    6
`define VS_POL_OVR    5
`define VS_POL        4
`define VS_OUT_POL    3
`define VS_FILT       2
`define VS_DUR_EN     1
`define CO_SRC        7
`define CO_POL_OVR    6
`define CO_POL        5
`define CL_EXT        4
`define CL_MID_HI     3
`define CL_MID_LO     1
`define CL_POL_OVR    7
`define CL_POL        6
`define AUTO_OFS      5
`define UPD_HI        4
`define UPD_LO        3

`define UPD_LAST16    4'hf
`define UPD_LAST64    6'h3f

`endif

// ---- verilog/vclamp_pkg.sv ----
/*
  Types shared by the vertical sync, coast and clamp control block.
  Assumes nothing of its surroundings.
*/
package vclamp_pkg;
    typedef enum logic [1:0] {
        CLAMP_IDLE,
        CLAMP_WAIT,
        CLAMP_ON
    } clamp_state_type;

    typedef enum logic [1:0] {
        UPD_EVERY,
        UPD_EVERY16,
        UPD_EVERY64,
        UPD_FRAME
    } upd_mode_type;
endpackage

// ---- verilog/vsync_coast_clamp_control.sv ----
/*
  Vertical sync source, polarity, filter and width; coast windows around
  vertical sync; internal or external clamp pulse; per-channel clamp
  target and auto-offset update strobe; byte register port.
  Assumes: CLK_I is the pixel clock, all pins are synchronous to it and
  HSYNC_I is the processed horizontal sync, active high.
*/
// Chosen here: strobed register access.
`timescale 1ns/100ps
`include "vclamp_regs.svh"

// Contract
// - override clear lets device pick vsync source
// - override set: select bit picks pin or separator
// - polarity override clear means automatic detection
// - user polarity bit: zero low, one high
// - output polarity bit sets vsync output level
// - filter aligns vsync to horizontal sync
// - duration enable replaces pass-through width
// - eight-bit width value, reset ten
// - coast starts lead lines before vsync
// - coast extends trail lines after vsync
// - coast from vsync or external pin
// - coast polarity automatic or user bit
// - clamp internal or from external pin
// - clamp all channels while clamp active
// - per-channel target ground or midscale
// - clamp starts placement pixels after hsync
// - clamp lasts duration pixels
// - external clamp ignores placement and duration
// - clamp polarity automatic or user bit
// - auto-offset enable bit selects offset mode
// - offset refresh rate by update code
module vsync_coast_clamp_control
    import vclamp_pkg::*;
#(
    parameter int LINE_W = 11,
    parameter int DET_W  = 4
) (
    input  wire logic       CLK_I,
    input  wire logic       RST_B_I,
    input  wire logic [7:0] ADDR_I,
    input  wire logic [7:0] WDATA_I,
    input  wire logic       WR_I,
    input  wire logic       RD_I,
    output logic      [7:0] RDATA_O,
    input  wire logic       VSYNC_PIN_I,
    input  wire logic       VSYNC_SEP_I,
    input  wire logic       HSYNC_I,
    input  wire logic       COAST_PIN_I,
    input  wire logic       CLAMP_PIN_I,
    output logic            VSYNC_O,
    output logic            COAST_O,
    output logic            CLAMP_O,
    output logic      [2:0] CLAMP_MID_O,
    output logic            AUTO_OFFSET_O,
    output logic            OFFSET_UPDATE_O
);

    if (LINE_W < 9 || LINE_W > 16) begin : g_chk_line
        $error("LINE_W must lie in 9..16");
    end
    if (DET_W < 2 || DET_W > 8) begin : g_chk_det
        $error("DET_W must lie in 2..8");
    end

    function automatic logic reg_hit(input logic [7:0] a);
        reg_hit = (a >= `VS_CTRL_ADDR) && (a <= `CL_POL_ADDR);
    endfunction

    function automatic logic [2:0] reg_idx(input logic [7:0] a);
        logic [7:0] d;
        d = a - `VS_CTRL_ADDR;
        reg_idx = d[2:0];
    endfunction

    function automatic logic [7:0] reg_rst(input logic [2:0] i);
        case (i)
            3'h0:    reg_rst = `VS_CTRL_RST;
            3'h1:    reg_rst = `VS_WIDTH_RST;
            3'h2:    reg_rst = `LEAD_RST;
            3'h3:    reg_rst = `TRAIL_RST;
            3'h4:    reg_rst = `CC_SEL_RST;
            3'h5:    reg_rst = `CL_START_RST;
            3'h6:    reg_rst = `CL_WIDTH_RST;
            default: reg_rst = `CL_POL_RST;
        endcase
    endfunction

    // bit 0 of the two control registers is not implemented
    function automatic logic [7:0] reg_mask(input logic [2:0] i);
        reg_mask = (i == 3'h0 || i == 3'h4) ? `LOW_BIT_MASK : `FULL_MASK;
    endfunction

    // a raw level turned into "active" under the given polarity
    function automatic logic as_active(input logic raw, input logic pol);
        as_active = ~(raw ^ pol);
    endfunction

    logic [7:0]       regs_r [`REG_NUM];
    logic [7:0]       regs_nxt [`REG_NUM];
    logic [7:0]       rdata_nxt;
    logic [7:0]       status;

    logic [7:0]       vs_ctrl;
    logic [7:0]       cc_sel;
    logic [7:0]       cl_pol;
    assign vs_ctrl = regs_r[0];
    assign cc_sel  = regs_r[4];
    assign cl_pol  = regs_r[7];

    // register port: reads answer one cycle later, unmapped reads give zero
    always_comb begin
        for (int i = 0; i < `REG_NUM; i++) begin
            regs_nxt[i] = regs_r[i];
        end
        if (WR_I && reg_hit(ADDR_I)) begin
            regs_nxt[reg_idx(ADDR_I)] = WDATA_I & reg_mask(reg_idx(ADDR_I));
        end
        rdata_nxt = 8'h00;
        if (RD_I && reg_hit(ADDR_I)) begin
            rdata_nxt = regs_r[reg_idx(ADDR_I)];
        end else if (RD_I && ADDR_I == `STATUS_ADDR) begin
            rdata_nxt = status;
        end
    end

    always_ff @(posedge CLK_I or negedge RST_B_I) begin
        if (!RST_B_I) begin
            for (int i = 0; i < `REG_NUM; i++) begin
                regs_r[i] <= reg_rst(3'(i));
            end
            RDATA_O <= 8'h00;
        end else begin
            regs_r  <= regs_nxt;
            RDATA_O <= rdata_nxt;
        end
    end

    // edge detection on incoming syncs
    logic hs_prev_r;
    logic vpin_prev_r;
    logic hs_lead;
    logic hs_trail;
    assign hs_lead  = HSYNC_I & ~hs_prev_r;
    assign hs_trail = ~HSYNC_I & hs_prev_r;

    // pin activity: any edge within the last 256 lines counts as present
    logic       pin_act_r;
    logic       pin_act_nxt;
    logic [7:0] idle_lines_r;
    logic [7:0] idle_lines_nxt;

    always_comb begin
        pin_act_nxt    = pin_act_r;
        idle_lines_nxt = idle_lines_r;
        if (VSYNC_PIN_I != vpin_prev_r) begin
            pin_act_nxt    = 1'b1;
            idle_lines_nxt = 8'h00;
        end else if (hs_lead) begin
            idle_lines_nxt = idle_lines_r + 8'h01;
            if (idle_lines_r == 8'hff) begin
                pin_act_nxt = 1'b0;
            end
        end
    end

    always_ff @(posedge CLK_I or negedge RST_B_I) begin
        if (!RST_B_I) begin
            hs_prev_r    <= 1'b0;
            vpin_prev_r  <= 1'b0;
            pin_act_r    <= 1'b0;
            idle_lines_r <= 8'h00;
        end else begin
            hs_prev_r    <= HSYNC_I;
            vpin_prev_r  <= VSYNC_PIN_I;
            pin_act_r    <= pin_act_nxt;
            idle_lines_r <= idle_lines_nxt;
        end
    end

    // the chip prefers the pin while it toggles, else the separator
    logic use_sep;
    logic vs_raw;
    assign use_sep = vs_ctrl[`VS_SRC_OVR] ? vs_ctrl[`VS_SRC_SEL]
                                          : ~pin_act_r;
    assign vs_raw  = use_sep ? VSYNC_SEP_I : VSYNC_PIN_I;

    // automatic polarity: syncs are short, so the idle level dominates;
    // vsync and coast are sampled once a line, clamp once a pixel, since a
    // pulse of 2**(DET_W-1) samples or more would flip the decision
    logic [2:0]       det_raw;
    logic [2:0]       det_ovr;
    logic [2:0]       det_usr;
    logic [2:0]       det_pol;
    logic [2:0]       det_act;
    logic [2:0]       det_tick;
    logic [DET_W-1:0] det_cnt_r [3];
    logic [DET_W-1:0] det_cnt_nxt [3];
    assign det_raw = {CLAMP_PIN_I, COAST_PIN_I, vs_raw};
    assign det_ovr = {cl_pol[`CL_POL_OVR], cc_sel[`CO_POL_OVR], vs_ctrl[`VS_POL_OVR]};
    assign det_usr = {cl_pol[`CL_POL], cc_sel[`CO_POL], vs_ctrl[`VS_POL]};
    assign det_tick = {1'b1, hs_lead, hs_lead};

    for (genvar g = 0; g < 3; g++) begin : g_det
        always_comb begin
            det_cnt_nxt[g] = det_cnt_r[g];
            if (det_tick[g] && det_raw[g] && det_cnt_r[g] != '1) begin
                det_cnt_nxt[g] = det_cnt_r[g] + 1'b1;
            end else if (det_tick[g] && !det_raw[g] && det_cnt_r[g] != '0) begin
                det_cnt_nxt[g] = det_cnt_r[g] - 1'b1;
            end
            det_pol[g] = det_ovr[g] ? det_usr[g] : ~det_cnt_r[g][DET_W-1];
            det_act[g] = as_active(det_raw[g], det_pol[g]);
        end

        always_ff @(posedge CLK_I or negedge RST_B_I) begin
            if (!RST_B_I) begin
                det_cnt_r[g] <= '0;
            end else begin
                det_cnt_r[g] <= det_cnt_nxt[g];
            end
        end
    end

    logic vs_act;
    logic co_pin_act;
    logic cl_pin_act;
    assign vs_act     = det_act[0];
    assign co_pin_act = det_act[1];
    assign cl_pin_act = det_act[2];

    // vertical path: filter, width, line count and coast windows
    logic              vf_r;
    logic              vf_nxt;
    logic              vf_prev_r;
    logic [7:0]        dur_r;
    logic [7:0]        dur_nxt;
    logic [LINE_W-1:0] line_r;
    logic [LINE_W-1:0] line_nxt;
    logic [LINE_W-1:0] flen_r;
    logic [LINE_W-1:0] flen_nxt;
    logic [7:0]        post_r;
    logic [7:0]        post_nxt;
    logic              vf_rise;
    logic              vf_up;
    logic              vf_down;
    logic              vs_out_act;
    logic              pre_win;
    logic              coast_int;
    logic [LINE_W:0]   line_ahead;

    assign vf_rise = vf_r & ~vf_prev_r;
    assign line_ahead = {1'b0, line_r} + (LINE_W+1)'(regs_r[2]);

    always_comb begin
        // filtered vsync only moves at the leading edge of a line
        vf_nxt = vs_act;
        if (vs_ctrl[`VS_FILT] && !hs_lead) begin
            vf_nxt = vf_r;
        end
        // width and trail load with the edge itself, so they span whole lines
        vf_up   = vf_nxt & ~vf_r;
        vf_down = ~vf_nxt & vf_r;
        dur_nxt = dur_r;
        if (vf_up) begin
            dur_nxt = regs_r[1];
        end else if (hs_lead && dur_r != 8'h00) begin
            dur_nxt = dur_r - 8'h01;
        end
        line_nxt = line_r;
        flen_nxt = flen_r;
        if (vf_rise) begin
            line_nxt = '0;
            flen_nxt = line_r;
        end else if (hs_lead && line_r != '1) begin
            line_nxt = line_r + 1'b1;
        end
        post_nxt = post_r;
        if (vf_down) begin
            post_nxt = regs_r[3];
        end else if (hs_lead && post_r != 8'h00) begin
            post_nxt = post_r - 8'h01;
        end
        vs_out_act = vs_ctrl[`VS_DUR_EN] ? (dur_r != 8'h00) : vf_r;
        // lead window predicted from the previous frame's line count
        pre_win = (regs_r[2] != 8'h00) && (flen_r != '0)
                  && (line_ahead >= {1'b0, flen_r});
        coast_int = pre_win | vf_r | (post_r != 8'h00);
    end

    always_ff @(posedge CLK_I or negedge RST_B_I) begin
        if (!RST_B_I) begin
            vf_r      <= 1'b0;
            vf_prev_r <= 1'b0;
            dur_r     <= 8'h00;
            line_r    <= '0;
            flen_r    <= '0;
            post_r    <= 8'h00;
        end else begin
            vf_r      <= vf_nxt;
            vf_prev_r <= vf_r;
            dur_r     <= dur_nxt;
            line_r    <= line_nxt;
            flen_r    <= flen_nxt;
            post_r    <= post_nxt;
        end
    end

    // internal clamp timing in pixel clocks from the hsync trailing edge
    clamp_state_type st_r;
    clamp_state_type st_nxt;
    logic [7:0]      ccnt_r;
    logic [7:0]      ccnt_nxt;
    logic            cl_ext;
    assign cl_ext = cc_sel[`CL_EXT];

    always_comb begin
        st_nxt   = st_r;
        ccnt_nxt = ccnt_r;
        case (st_r)
            CLAMP_IDLE: begin
                if (hs_trail && !cl_ext) begin
                    st_nxt   = CLAMP_WAIT;
                    ccnt_nxt = regs_r[5];
                end
            end
            CLAMP_WAIT: begin
                // a zero setting is treated as one rather than wrapping
                if (ccnt_r <= 8'h01) begin
                    st_nxt   = CLAMP_ON;
                    ccnt_nxt = regs_r[6];
                end else begin
                    ccnt_nxt = ccnt_r - 8'h01;
                end
            end
            CLAMP_ON: begin
                if (ccnt_r <= 8'h01) begin
                    st_nxt = CLAMP_IDLE;
                end else begin
                    ccnt_nxt = ccnt_r - 8'h01;
                end
            end
            default: begin
                st_nxt = CLAMP_IDLE;
            end
        endcase
        if (cl_ext) begin
            st_nxt = CLAMP_IDLE;
        end
    end

    always_ff @(posedge CLK_I or negedge RST_B_I) begin
        if (!RST_B_I) begin
            st_r   <= CLAMP_IDLE;
            ccnt_r <= 8'h00;
        end else begin
            st_r   <= st_nxt;
            ccnt_r <= ccnt_nxt;
        end
    end

    // outputs and auto-offset update strobe
    logic         vs_o_nxt;
    logic         co_o_nxt;
    logic         cl_o_nxt;
    logic         upd_nxt;
    logic         cl_fall;
    logic [5:0]   pcnt_r;
    logic [5:0]   pcnt_nxt;
    upd_mode_type umode;
    assign umode = upd_mode_type'({cl_pol[`UPD_HI], cl_pol[`UPD_LO]});

    always_comb begin
        vs_o_nxt = as_active(vs_out_act, vs_ctrl[`VS_OUT_POL]);
        co_o_nxt = cc_sel[`CO_SRC] ? co_pin_act : coast_int;
        cl_o_nxt = cl_ext ? cl_pin_act : (st_nxt == CLAMP_ON);
        cl_fall  = CLAMP_O & ~cl_o_nxt;
        pcnt_nxt = pcnt_r;
        upd_nxt  = 1'b0;
        if (cl_fall) begin
            pcnt_nxt = pcnt_r + 6'h01;
        end
        case (umode)
            UPD_EVERY:   upd_nxt = cl_fall;
            UPD_EVERY16: upd_nxt = cl_fall && pcnt_r[3:0] == `UPD_LAST16;
            UPD_EVERY64: upd_nxt = cl_fall && pcnt_r == `UPD_LAST64;
            UPD_FRAME:   upd_nxt = vf_rise;
            default:     upd_nxt = 1'b0;
        endcase
        upd_nxt = upd_nxt & cl_pol[`AUTO_OFS];
    end

    always_ff @(posedge CLK_I or negedge RST_B_I) begin
        if (!RST_B_I) begin
            VSYNC_O         <= 1'b0;
            COAST_O         <= 1'b0;
            CLAMP_O         <= 1'b0;
            OFFSET_UPDATE_O <= 1'b0;
            pcnt_r          <= 6'h00;
        end else begin
            VSYNC_O         <= vs_o_nxt;
            COAST_O         <= co_o_nxt;
            CLAMP_O         <= cl_o_nxt;
            OFFSET_UPDATE_O <= upd_nxt;
            pcnt_r          <= pcnt_nxt;
        end
    end

    // these sit directly on register flip-flops
    assign CLAMP_MID_O   = cc_sel[`CL_MID_HI:`CL_MID_LO];
    assign AUTO_OFFSET_O = cl_pol[`AUTO_OFS];

    assign status = {det_pol, use_sep, pin_act_r, st_r == CLAMP_ON, coast_int, vf_r};

    default clocking cb @(posedge CLK_I); endclocking
    default disable iff (!RST_B_I);

    src_auto_a: assert property (!vs_ctrl[`VS_SRC_OVR] |-> use_sep == !pin_act_r)
        else $error("auto vsync source wrong");
    src_user_a: assert property ((vs_ctrl[`VS_SRC_OVR] && !vs_ctrl[`VS_SRC_SEL])
        |-> vs_raw == VSYNC_PIN_I)
        else $error("user vsync source wrong");
    in_pol_a: assert property (vs_ctrl[`VS_POL_OVR]
        |-> vs_act == (vs_raw == vs_ctrl[`VS_POL]))
        else $error("vsync input polarity wrong");
    out_pol_a: assert property (1'b1 |=> VSYNC_O == ($past(vs_out_act)
        == $past(vs_ctrl[`VS_OUT_POL])))
        else $error("vsync output polarity wrong");
    filt_hold_a: assert property ((vs_ctrl[`VS_FILT] && !hs_lead)
        |=> $stable(vf_r))
        else $error("filtered vsync moved off line edge");
    width_load_a: assert property (vf_up |=> dur_r == $past(regs_r[1]))
        else $error("vsync width not loaded");
    trail_load_a: assert property (vf_down |=> post_r == $past(regs_r[3]))
        else $error("trail lines not loaded");
    coast_pin_a: assert property (cc_sel[`CO_SRC] |=> COAST_O == $past(co_pin_act))
        else $error("coast pin not followed");
    clamp_ext_a: assert property (cl_ext ##1 cl_ext
        |-> CLAMP_O == $past(cl_pin_act) && st_r == CLAMP_IDLE)
        else $error("external clamp not followed");
    clamp_start_a: assert property ((st_r == CLAMP_IDLE && hs_trail && !cl_ext)
        |=> st_r == CLAMP_WAIT && ccnt_r == $past(regs_r[5]))
        else $error("clamp placement not loaded");
    clamp_len_a: assert property ((st_r == CLAMP_WAIT && st_nxt == CLAMP_ON)
        |=> ccnt_r == $past(regs_r[6]))
        else $error("clamp duration not loaded");
    upd_gate_a: assert property (OFFSET_UPDATE_O |-> $past(cl_pol[`AUTO_OFS]))
        else $error("offset update without auto mode");

    clamp_pulse_c: cover property ($rose(CLAMP_O) && !cl_ext);
    coast_win_c: cover property (pre_win && !vf_r);
    width_on_c: cover property (vs_ctrl[`VS_DUR_EN] && vf_rise);
    offset_upd_c: cover property (OFFSET_UPDATE_O);

endmodule

// ---- dv/video_source.sv ----
/*
  Video source model: hsync, vsync on pin and separator, coast and clamp pins.
  Assumes the block's pixel clock and its active-low reset.
*/
`timescale 1ns/100ps
module video_source #(
    parameter int LINE  = 40,
    parameter int LINES = 12
) (
    input  wire logic clk_i,
    input  wire logic rst_b_i,
    input  wire logic pol_i,
    output logic      hsync_o,
    output logic      vpin_o,
    output logic      vsep_o,
    output logic      coast_o,
    output logic      clamp_o
);
    int pix_r;
    int line_r;
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            pix_r  <= 0;
            line_r <= 0;
        end else begin
            pix_r <= (pix_r == LINE - 1) ? 0 : pix_r + 1;
            if (pix_r == LINE - 1)
                line_r <= (line_r == LINES - 1) ? 0 : line_r + 1;
        end
    end
    // vsync edges sit on hsync leading edges, so filtered width equals raw width
    always_comb begin
        hsync_o = rst_b_i && pix_r < 4;
        vpin_o  = (line_r < 3) ~^ pol_i;
        vsep_o  = line_r >= 5 && line_r < 9;
        coast_o = (line_r == 6) ~^ pol_i;
        clamp_o = (pix_r >= 10 && pix_r < 16) ~^ pol_i;
    end
endmodule

// ---- dv/vsync_coast_clamp_control_test.sv ----
/*
  Self-checking bench for the vertical sync, coast and clamp block.
  Assumes the video source model drives every sync pin on the same clock.
*/
`timescale 1ns/100ps
module vsync_coast_clamp_control_test;
    localparam int LIM = 9000;
    localparam int SETTLE = 1440;
    localparam logic [7:0] RST_V [8] = '{8'h18, 8'h0a, 8'h00, 8'h00,
                                         8'h20, 8'h08, 8'h14, 8'h58};
    logic       clk = 0;
    logic       rst_b = 0;
    logic [7:0] addr = 0;
    logic [7:0] wdata = 0;
    logic       wr_s = 0;
    logic       rd_s = 0;
    logic       pol = 0;
    logic       inv = 0;
    logic       h_d = 0;
    int         hf_cnt = 0;
    int         bad_count = 0;
    int         n_compared = 0;
    logic [7:0] rdata;
    logic [2:0] mid_o;
    logic       hs, vpin, vsep, kpin, cpin, vs_o, co_o, cl_o, au_o, up_o;

    video_source i_video_source (.clk_i(clk), .rst_b_i(rst_b), .pol_i(pol),
        .hsync_o(hs), .vpin_o(vpin), .vsep_o(vsep), .coast_o(kpin), .clamp_o(cpin));

    vsync_coast_clamp_control i_vsync_coast_clamp_control (.CLK_I(clk),
        .RST_B_I(rst_b), .ADDR_I(addr), .WDATA_I(wdata), .WR_I(wr_s),
        .RD_I(rd_s), .RDATA_O(rdata), .VSYNC_PIN_I(vpin), .VSYNC_SEP_I(vsep),
        .HSYNC_I(hs), .COAST_PIN_I(kpin), .CLAMP_PIN_I(cpin), .VSYNC_O(vs_o),
        .COAST_O(co_o), .CLAMP_O(cl_o), .CLAMP_MID_O(mid_o),
        .AUTO_OFFSET_O(au_o), .OFFSET_UPDATE_O(up_o));

    initial begin
        forever #12.5 clk = ~clk;
    end

    // cycles since the last hsync trailing edge
    always @(posedge clk) begin
        h_d    <= hs;
        hf_cnt <= (h_d && !hs) ? 0 : hf_cnt + 1;
    end

    task automatic report_and_stop();
        $display("compared %0d, mismatches %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            bad_count++;
            $display("[ERR] %0t got %0d expected %0d", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        addr  <= a;
        wdata <= d;
        wr_s  <= 1'b1;
        @(posedge clk);
        wr_s  <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge clk);
        addr <= a;
        rd_s <= 1'b1;
        @(posedge clk);
        rd_s <= 1'b0;
        @(negedge clk);
        d = {24'h0, rdata};
    endtask

    function automatic logic pick(input int s);
        case (s)
            0: pick = vs_o ^ inv;
            1: pick = co_o;
            2: pick = cl_o;
            default: pick = up_o;
        endcase
    endfunction

    // lets polarity learning settle for three frames, then skips one pulse
    // so a settings change never yields a partial one
    task automatic pulse(input int s, output int w, output int p, output int d);
        int n;
        int t0;
        repeat (SETTLE) @(negedge clk);
        n = 0;
        t0 = 0;
        w = 0;
        d = 0;
        for (int k = 0; k < 6; k++) begin
            while (pick(s) !== k[0] && n < LIM) begin
                @(negedge clk);
                n++;
            end
            if (k == 3) begin
                t0 = n;
                d = hf_cnt;
            end
            if (k == 4)
                w = n - t0;
        end
        p = n - t0;
        if (n >= LIM) begin
            bad_count++;
            $display("[ERR] %0t no pulse on output %0d", $time, s);
            report_and_stop();
        end
    endtask

    task automatic t_regs();
        logic [31:0] d;
        for (int i = 0; i < 8; i++) begin
            rd(8'h14 + 8'(i), d);
            chk(d, {24'h0, RST_V[i]});
            wr(8'h14 + 8'(i), 8'ha5);
            rd(8'h14 + 8'(i), d);
            chk(d, (i == 0 || i == 4) ? 32'ha4 : 32'ha5);
            wr(8'h14 + 8'(i), RST_V[i]);
        end
        rd(8'h3f, d);
        chk(d, 0);
        wr(8'h18, 8'h2a);
        wr(8'h1b, 8'h78);
        @(negedge clk);
        chk({29'h0, mid_o}, 5);
        chk({31'h0, au_o}, 1);
        wr(8'h18, 8'h20);
        wr(8'h1b, 8'h58);
        $display("registers done");
    endtask

    task automatic t_vsync();
        int w, p, d;
        pulse(0, w, p, d);
        chk(w, 120);
        chk(p, 480);
        inv = 1'b1;
        wr(8'h14, 8'ha0);
        pulse(0, w, p, d);
        chk(w, 120);
        wr(8'h14, 8'hb0);
        pulse(0, w, p, d);
        chk(w, 360);
        inv = 1'b0;
        wr(8'h14, 8'hd8);
        pulse(0, w, p, d);
        chk(w, 160);
        wr(8'h14, 8'hac);
        pulse(0, w, p, d);
        chk(w, 120);
        wr(8'h15, 8'h02);
        wr(8'h14, 8'hae);
        pulse(0, w, p, d);
        chk(w, 80);
        wr(8'h14, 8'hac);
        $display("vsync done");
    endtask

    task automatic t_coast();
        int w, p, d;
        pulse(1, w, p, d);
        chk(w, 120);
        wr(8'h16, 8'h02);
        wr(8'h17, 8'h03);
        pulse(1, w, p, d);
        chk(w, 320);
        pol <= 1'b1;
        wr(8'h18, 8'he0);
        pulse(1, w, p, d);
        chk(w, 40);
        pol <= 1'b0;
        pulse(1, w, p, d);
        chk(w, 440);
        wr(8'h18, 8'hc0);
        pulse(1, w, p, d);
        chk(w, 40);
        wr(8'h18, 8'h80);
        pulse(1, w, p, d);
        chk(w, 40);
        wr(8'h18, 8'h20);
        $display("coast done");
    endtask

    task automatic t_clamp();
        int w, p, d, d2;
        wr(8'h19, 8'h02);
        wr(8'h1a, 8'h03);
        pulse(2, w, p, d2);
        chk(w, 3);
        chk(p, 40);
        wr(8'h19, 8'h09);
        wr(8'h1a, 8'h01);
        pulse(2, w, p, d);
        chk(d - d2, 7);
        chk(w, 1);
        pol <= 1'b1;
        wr(8'h18, 8'h30);
        wr(8'h1b, 8'hd8);
        pulse(2, w, p, d);
        chk(w, 6);
        wr(8'h1b, 8'h98);
        pulse(2, w, p, d);
        chk(w, 34);
        pol <= 1'b0;
        pulse(2, w, p, d);
        chk(w, 6);
        wr(8'h1b, 8'h58);
        pulse(2, w, p, d);
        chk(w, 6);
        wr(8'h18, 8'h20);
        wr(8'h19, 8'h08);
        wr(8'h1a, 8'h14);
        $display("clamp done");
    endtask

    task automatic t_offset();
        int w, p, d, n;
        int per [4] = '{40, 640, 2560, 480};
        for (int m = 0; m < 4; m++) begin
            wr(8'h1b, 8'h60 | 8'(m << 3));
            pulse(3, w, p, d);
            chk(p, per[m]);
        end
        wr(8'h1b, 8'h58);
        n = 0;
        repeat (1000) begin
            @(negedge clk);
            if (up_o !== 1'b0)
                n++;
        end
        chk(n, 0);
        $display("offset done");
    endtask

    initial begin
        repeat (16) @(posedge clk);
        rst_b <= 1'b1;
        t_regs();
        t_vsync();
        t_coast();
        t_clamp();
        t_offset();
        report_and_stop();
    end
endmodule
